// [src/bfi_top.sv]
// Bus-fault flag register and interrupt enable registers of a CAN FD transceiver.
// Assumes the serial front end presents one byte access per cycle on a simple
// address/strobe port, and that fault detectors give synchronous levels.
`timescale 1ns/100ps

module bfi_top
(
	// Clock and reset
	input  wire logic                      CLK_I,
	input  wire logic                      RESET_N_I,
	// Register port
	input  wire logic [bfi_pkg::ADDR_W-1:0] ADDR_I,
	input  wire logic [bfi_pkg::DATA_W-1:0] WDATA_I,
	input  wire logic                      WR_I,
	input  wire logic                      RD_I,
	output logic [bfi_pkg::DATA_W-1:0]     RDATA_O,
	output logic                           RVALID_O,
	// Fault detector levels
	input  wire logic                      TERM_OPEN_I,
	input  wire logic                      HL_SHORT_I,
	input  wire logic                      H_BAT_I,
	input  wire logic                      L_GND_I,
	input  wire logic                      BUS_OPEN_I,
	input  wire logic                      BUS_GND_I,
	input  wire logic                      BUS_BAT_I,
	// Status towards the summary and interrupt logic
	output logic                           FAULT_SUMMARY_O,
	output logic                           FAULT_IRQ_O,
	output logic [bfi_pkg::DATA_W-1:0]     EVENT_EN_O,
	output logic [bfi_pkg::DATA_W-1:0]     SUPPLY_EN_O,
	output logic [bfi_pkg::DATA_W-1:0]     LINK_EN_O
);
	import bfi_pkg::*;

	// Enable registers carry field names so single sources can be picked out later
	typedef struct packed
	{
		logic watchdog_event_en;
		logic bus_wake_en;
		logic local_wake_en;
		logic wake_error_en;
		logic frame_overflow_en;
		logic bus_silent_en;
		logic bus_timeout_en;
		logic stuck_dominant_en;
	} bfi_event_en_s;

	typedef struct packed
	{
		logic [2:0] rsvd;
		logic       supply_uv_en;
		logic       io_uv_en;
		logic       core_uv_en;
		logic       thermal_shutdown_en;
		logic       thermal_warning_en;
	} bfi_supply_en_s;

	typedef struct packed
	{
		logic       serial_error_en;
		logic       selective_wake_error_en;
		logic       failsafe_entry_en;
		logic [4:0] rsvd;
	} bfi_link_en_s;

	typedef struct packed
	{
		logic rsvd;
		logic term_open_en;
		logic hl_short_en;
		logic h_bat_en;
		logic l_gnd_en;
		logic bus_open_en;
		logic bus_gnd_en;
		logic bus_bat_en;
	} bfi_fault_en_s;

	// Write selects, one per register that a write can change
	typedef struct packed
	{
		logic bus_fault;
		logic event_en;
		logic supply_en;
		logic link_en;
		logic fault_en;
	} bfi_wr_sel_s;

	typedef struct packed
	{
		bfi_event_en_s  event_en;
		bfi_supply_en_s supply_en;
		bfi_link_en_s   link_en;
		bfi_fault_en_s  fault_en;
		logic [7:0] rdata;
		logic       rvalid;
		logic       summary;
		logic       irq;
	} bfi_regs_s;

	bfi_regs_s              s_q;
	bfi_regs_s              s_d;
	bfi_wr_sel_s            wr_sel;
	logic [FAULT_W-1:0]     fault_set;
	logic [FAULT_W-1:0]     fault_clr;
	logic [FAULT_W-1:0]     flags;
	logic [7:0]             fault_reg;
	logic [7:0]             rd_mux;

	always_comb
	begin
		fault_set                    = '0;
		fault_set[BIT_TERM_OPEN]     = TERM_OPEN_I;
		fault_set[BIT_HL_SHORT]      = HL_SHORT_I;
		fault_set[BIT_H_BAT]         = H_BAT_I;
		fault_set[BIT_L_GND]         = L_GND_I;
		fault_set[BIT_BUS_OPEN]      = BUS_OPEN_I;
		fault_set[BIT_BUS_GND]       = BUS_GND_I;
		fault_set[BIT_BUS_BAT]       = BUS_BAT_I;
	end

	// One decoder feeds both the clear path and the enable writes
	always_comb
	begin
		wr_sel = '0;
		if (WR_I)
		begin
			unique case (ADDR_I)
				ADDR_BUS_FAULT: wr_sel.bus_fault = 1'b1;
				ADDR_EVENT_EN:  wr_sel.event_en  = 1'b1;
				ADDR_SUPPLY_EN: wr_sel.supply_en = 1'b1;
				ADDR_LINK_EN:   wr_sel.link_en   = 1'b1;
				ADDR_FAULT_EN:  wr_sel.fault_en  = 1'b1;
				// 55h, 5Ah..5Fh and unmapped addresses select nothing
				default:        wr_sel = '0;
			endcase
		end
	end

	// Reserved bit 7 is outside the mask, so it can never be cleared or set
	assign fault_clr = wr_sel.bus_fault ?
		WDATA_I[FAULT_W-1:0] & MASK_BUS_FAULT[FAULT_W-1:0] : '0;

	genvar g;
	generate
		for (g = 0; g < FAULT_W; g++)
		begin : g_flag
			bfi_w1c_flag u_flag
			(
				.clk_i     (CLK_I),
				.reset_n_i (RESET_N_I),
				.set_i     (fault_set[g]),
				.clear_i   (fault_clr[g]),
				.flag_o    (flags[g])
			);
		end
	endgenerate

	assign fault_reg = {1'b0, flags};

	always_comb
	begin
		rd_mux = RSVD_READ;
		unique case (ADDR_I)
			ADDR_BUS_FAULT:   rd_mux = fault_reg;
			ADDR_GLOBAL_MASK: rd_mux = RSVD_READ;
			ADDR_EVENT_EN:    rd_mux = s_q.event_en;
			ADDR_SUPPLY_EN:   rd_mux = s_q.supply_en;
			ADDR_LINK_EN:     rd_mux = s_q.link_en;
			ADDR_FAULT_EN:    rd_mux = s_q.fault_en;
			// 5Ah..5Fh and any unmapped address read zero
			default:          rd_mux = RSVD_READ;
		endcase
	end

	always_comb
	begin
		s_d        = s_q;
		s_d.rvalid = RD_I;
		if (RD_I)
			s_d.rdata = rd_mux;
		// Only writable bits take the data, so reserved bits stay zero
		if (wr_sel.event_en)
			s_d.event_en  = WDATA_I & MASK_EVENT_EN;
		if (wr_sel.supply_en)
			s_d.supply_en = WDATA_I & MASK_SUPPLY_EN;
		if (wr_sel.link_en)
			s_d.link_en   = WDATA_I & MASK_LINK_EN;
		if (wr_sel.fault_en)
			s_d.fault_en  = WDATA_I & MASK_FAULT_EN;
		// Summary and request follow the flags one cycle later, as registered outputs
		s_d.summary = |flags;
		s_d.irq     = |(flags & {s_q.fault_en.term_open_en, s_q.fault_en.hl_short_en,
			s_q.fault_en.h_bat_en, s_q.fault_en.l_gnd_en, s_q.fault_en.bus_open_en,
			s_q.fault_en.bus_gnd_en, s_q.fault_en.bus_bat_en});
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I)
	begin
		if (!RESET_N_I)
		begin
			s_q.event_en  <= RST_EVENT_EN;
			s_q.supply_en <= RST_SUPPLY_EN;
			s_q.link_en   <= RST_LINK_EN;
			s_q.fault_en  <= RST_FAULT_EN;
			s_q.rdata     <= '0;
			s_q.rvalid    <= 1'b0;
			s_q.summary   <= 1'b0;
			s_q.irq       <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	assign RDATA_O         = s_q.rdata;
	assign RVALID_O        = s_q.rvalid;
	assign FAULT_SUMMARY_O = s_q.summary;
	assign FAULT_IRQ_O     = s_q.irq;
	assign EVENT_EN_O      = s_q.event_en;
	assign SUPPLY_EN_O     = s_q.supply_en;
	assign LINK_EN_O       = s_q.link_en;
endmodule // bfi_top

// [src/bfi_pkg.sv]
// Package for the bus-fault flag and interrupt enable register group.
// Assumes a byte-wide register port with 8-bit addresses from the serial front end.
package bfi_pkg;
	localparam int          DATA_W            = 8;
	localparam int          ADDR_W            = 8;
	localparam int          FAULT_W           = 7;
	// Register addresses
	localparam logic [7:0]  ADDR_BUS_FAULT    = 8'h54;
	localparam logic [7:0]  ADDR_GLOBAL_MASK  = 8'h55;
	localparam logic [7:0]  ADDR_EVENT_EN     = 8'h56;
	localparam logic [7:0]  ADDR_SUPPLY_EN    = 8'h57;
	localparam logic [7:0]  ADDR_LINK_EN      = 8'h58;
	localparam logic [7:0]  ADDR_FAULT_EN     = 8'h59;
	localparam logic [7:0]  ADDR_RSVD_FIRST   = 8'h5a;
	localparam logic [7:0]  ADDR_RSVD_LAST    = 8'h5f;
	// Reset values
	localparam logic [7:0]  RST_BUS_FAULT     = 8'h00;
	localparam logic [7:0]  RST_EVENT_EN      = 8'hff;
	localparam logic [7:0]  RST_SUPPLY_EN     = 8'h1f;
	localparam logic [7:0]  RST_LINK_EN       = 8'ha0;
	localparam logic [7:0]  RST_FAULT_EN      = 8'h7f;
	localparam logic [7:0]  RSVD_READ         = 8'h00;
	// Writable bit masks
	localparam logic [7:0]  MASK_BUS_FAULT    = 8'h7f;
	localparam logic [7:0]  MASK_EVENT_EN     = 8'hff;
	localparam logic [7:0]  MASK_SUPPLY_EN    = 8'h1f;
	localparam logic [7:0]  MASK_LINK_EN      = 8'he0;
	localparam logic [7:0]  MASK_FAULT_EN     = 8'h7f;
	// Fault bit positions
	localparam int          BIT_TERM_OPEN     = 6;
	localparam int          BIT_HL_SHORT      = 5;
	localparam int          BIT_H_BAT         = 4;
	localparam int          BIT_L_GND         = 3;
	localparam int          BIT_BUS_OPEN      = 2;
	localparam int          BIT_BUS_GND       = 1;
	localparam int          BIT_BUS_BAT       = 0;
	// Summary bit position in the global interrupt summary
	localparam int          BIT_SUMMARY_FAULT = 3;
endpackage : bfi_pkg

// [src/bfi_w1c_flag.sv]
// One sticky fault flag, set by hardware, cleared by writing one.
// Assumes the set input is a level or pulse synchronous to CLK_I.
`timescale 1ns/100ps
module bfi_w1c_flag
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	// Control
	input  wire logic set_i,
	input  wire logic clear_i,
	// State
	output logic      flag_o
);
	typedef struct packed
	{
		logic flag;
	} bfi_flag_s;

	bfi_flag_s s_q;
	bfi_flag_s s_d;

	always_comb
	begin
		s_d = s_q;
		// Set wins over a clear in the same cycle so no fault is lost
		if (set_i)
			s_d.flag = 1'b1;
		else if (clear_i)
			s_d.flag = 1'b0;
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign flag_o = s_q.flag;
endmodule // bfi_w1c_flag

// [sim/bfi_chk.sv]
// Port checker for the bus-fault flag and enable register group.
// Assumes one clock domain and binding onto bfi_top.
`timescale 1ns/100ps
module bfi_chk
(
	// Clock, reset and register port
	input wire logic       CLK_I,
	input wire logic       RESET_N_I,
	input wire logic [7:0] ADDR_I,
	input wire logic       WR_I,
	input wire logic       RD_I,
	input wire logic [7:0] RDATA_O,
	input wire logic       RVALID_O,
	// Faults and status
	input wire logic       TERM_OPEN_I,
	input wire logic       BUS_BAT_I,
	input wire logic       FAULT_SUMMARY_O,
	input wire logic       FAULT_IRQ_O,
	input wire logic [7:0] EVENT_EN_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESET_N_I);
	sequence s_fault;
		TERM_OPEN_I || BUS_BAT_I;
	endsequence
	sequence s_rd_rsvd;
		RD_I && ADDR_I inside {[8'h5a:8'h5f]};
	endsequence
	chk_rd_answer: assert property (RD_I |=> RVALID_O)
		else $error("read not answered");
	chk_rd_single: assert property (!RD_I |=> !RVALID_O)
		else $error("stray read valid");
	chk_fault_summary: assert property (s_fault |-> ##2 FAULT_SUMMARY_O)
		else $error("fault not summarised");
	chk_irq_gated: assert property (FAULT_IRQ_O |-> FAULT_SUMMARY_O)
		else $error("request without flag");
	chk_mask_zero: assert property (RD_I && ADDR_I == 8'h55 |=> RDATA_O == 8'h00)
		else $error("global mask not zero");
	chk_rsvd_zero: assert property (s_rd_rsvd |=> RDATA_O == 8'h00)
		else $error("reserved space not zero");
	chk_flag_top: assert property (RD_I && ADDR_I == 8'h54 |=> !RDATA_O[7])
		else $error("flag bit 7 set");
	chk_en_hold: assert property (!(WR_I && ADDR_I == 8'h56) |=> $stable(EVENT_EN_O))
		else $error("event enable moved");
endmodule // bfi_chk

// [sim/bfi_wiring_model.sv]
// Model of the monitored bus wiring: requested faults become detector levels.
// Assumes requests change at the falling clock edge.
`timescale 1ns/100ps
module bfi_wiring_model
(
	// Requested faults, bit 6 termination open down to bit 0 bus to battery
	input  wire logic [6:0] req_i,
	// Detector levels
	output logic [6:0]      flt_o
);
	// Healthy wiring shows no fault; a fault shows only while requested
	assign flt_o = req_i;
endmodule // bfi_wiring_model

// [sim/bfi_top_tb.sv]
// Self-checking bench for the bus-fault flag and enable registers.
// Assumes package, design, wiring model and checker are compiled first.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module bfi_top_tb;
	import bfi_pkg::*;
	typedef struct { logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e; } bfi_row_s;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [6:0] req = 7'h00;
	logic [6:0] flt;
	logic [7:0] rdata, ev_en, sup_en, lnk_en;
	logic       rvalid, summ, irq;
	int         n_mismatch = 0;
	int         checks_done = 0;
	bfi_row_s   rows [16] = '{'{0, 8'h54, 0, 8'h00}, '{0, 8'h55, 0, 8'h00},
		'{0, 8'h56, 0, 8'hff}, '{0, 8'h57, 0, 8'h1f}, '{0, 8'h58, 0, 8'ha0},
		'{0, 8'h59, 0, 8'h7f}, '{1, 8'h56, 8'h5a, 8'h5a}, '{1, 8'h57, 8'hff, 8'h1f},
		'{1, 8'h58, 8'hff, 8'he0}, '{1, 8'h58, 8'h40, 8'h40}, '{1, 8'h59, 8'hff, 8'h7f},
		'{1, 8'h55, 8'hff, 8'h00}, '{1, 8'h5a, 8'hff, 8'h00}, '{1, 8'h5f, 8'hff, 8'h00},
		'{1, 8'h54, 8'h80, 8'h00}, '{1, 8'h60, 8'hff, 8'h00}};
	initial forever #5 clk = ~clk;
	bfi_wiring_model u_wire (.req_i(req), .flt_o(flt));
	bfi_top u_dut (.CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .RVALID_O(rvalid), .TERM_OPEN_I(flt[6]),
		.HL_SHORT_I(flt[5]), .H_BAT_I(flt[4]), .L_GND_I(flt[3]), .BUS_OPEN_I(flt[2]),
		.BUS_GND_I(flt[1]), .BUS_BAT_I(flt[0]), .FAULT_SUMMARY_O(summ), .FAULT_IRQ_O(irq),
		.EVENT_EN_O(ev_en), .SUPPLY_EN_O(sup_en), .LINK_EN_O(lnk_en));
	task automatic results();
		if (n_mismatch == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	// Read data arrives one cycle after the strobe; give up after a few cycles
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		int i;
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		for (i = 0; i < 4 && rvalid !== 1'b1; i++)
			@(posedge clk) #1;
		if (i == 4)
		begin
			n_mismatch++;
			results();
		end
		`CHK("rdata", e, rdata)
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		`CHK("link_en", 8'ha0, lnk_en)
		`CHK("supply_en", 8'h1f, sup_en)
		foreach (rows[k])
		begin
			if (rows[k].w)
				wr_reg(rows[k].a, rows[k].d);
			chk_rd(rows[k].a, rows[k].e);
		end
		wr_reg(8'h59, 8'h00);
		for (int b = 0; b < 7; b++)
		begin
			@(negedge clk) req = 7'(1 << b);
			@(negedge clk) req = 7'h00;
			@(negedge clk);
			`CHK("summary", 1'b1, summ)
			`CHK("irq", 1'b0, irq)
			chk_rd(8'h54, 8'(1 << b));
			wr_reg(8'h54, 8'(1 << b));
			chk_rd(8'h54, 8'h00);
		end
		// A fault still present must survive the clearing write
		wr_reg(8'h59, 8'h7f);
		req = 7'h01;
		wr_reg(8'h54, 8'h01);
		`CHK("irq", 1'b1, irq)
		chk_rd(8'h54, 8'h01);
		req = 7'h00;
		wr_reg(8'h54, 8'h01);
		chk_rd(8'h54, 8'h00);
		`CHK("summary", 1'b0, summ)
		// Reset in mid-run: a latched fault and written enables go back to reset values
		`CHK("event_en", 8'h5a, ev_en)
		req = 7'h40;
		@(negedge clk) req = 7'h00;
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		`CHK("event_en", 8'hff, ev_en)
		`CHK("link_en", 8'ha0, lnk_en)
		`CHK("irq", 1'b0, irq)
		chk_rd(8'h54, 8'h00);
		chk_rd(8'h59, 8'h7f);
		results();
	end
endmodule // bfi_top_tb
bind bfi_top bfi_chk u_chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .ADDR_I(ADDR_I),
	.WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .RVALID_O(RVALID_O),
	.TERM_OPEN_I(TERM_OPEN_I), .BUS_BAT_I(BUS_BAT_I), .FAULT_SUMMARY_O(FAULT_SUMMARY_O),
	.FAULT_IRQ_O(FAULT_IRQ_O), .EVENT_EN_O(EVENT_EN_O));
